// >>> sap_sequencer.sv
// Converter control sequencer: host strobes, hold, conversion, output latch
`timescale 1ns/1ns
`default_nettype none
module sap_sequencer
   import sap_pkg::*;
#(
   parameter int DATA_W  = SAP_DATA_W,
   parameter int BIT_DIV = SAP_BIT_DIV
) (
   input  wire logic              ref_clk,
   input  wire logic              sys_rst,
   input  wire logic              chip_sel_n,
   input  wire logic              wr_n,
   input  wire logic              rd_n,
   input  wire logic              alternate_timing_input,
   input  wire logic              use_alt_timing,
   input  wire logic              cmp_above,
   input  wire logic              over_range,
   input  wire logic              under_range,
   output logic [DATA_W-1:0]      dac_code,
   output logic                   hold_en,
   output logic                   eoc_n,
   output logic [DATA_W-1:0]      data_out,
   output logic                   data_oe
);
   typedef struct packed {
      logic [2:0]        cs_s;
      logic [2:0]        wr_s;
      logic [2:0]        rd_s;
      logic [2:0]        alt_s;
      logic [1:0]        cmp_s;
      logic [1:0]        ovr_s;
      logic [1:0]        und_s;
      logic [1:0]        alt_en_s;
      sap_state_t        state;
      logic [7:0]        div;
      logic [15:0]       conv_cnt;
      logic              start;
      logic [DATA_W-1:0] latch;
      logic [DATA_W-1:0] dac;
      logic              hold;
      logic              eoc_n;
      logic [DATA_W-1:0] dout;
      logic              oe;
   } sap_seq_t;

   sap_seq_t st_q;
   sap_seq_t st_d;

   logic              step;
   logic [DATA_W-1:0] sar_trial;
   logic [DATA_W-1:0] sar_result;
   logic              sar_done;

   function automatic logic rising(input logic [2:0] s);
      rising = s[1] & ~s[2];
   endfunction : rising

   function automatic logic falling(input logic [2:0] s);
      falling = ~s[1] & s[2];
   endfunction : falling

   ////////////////////////////////////////////////////////////////////////
   // Bit step: internal divider or rising edge of the alternate timing pin
   always_comb begin
      if (st_q.alt_en_s[1]) begin
         step = rising(st_q.alt_s);
      end else begin
         step = (st_q.div == 8'(BIT_DIV - 1));
      end
      // Early step would decide on the previous trial code
      if (st_q.conv_cnt < 16'(SAP_SETTLE_CYC)) begin
         step = 1'b0;
      end
   end

   sap_sar_core #(
      .WIDTH     (DATA_W)
   ) u_core (
      .ref_clk   (ref_clk),
      .sys_rst   (sys_rst),
      .start     (st_q.start),
      .step      (step),
      .cmp_above (st_q.cmp_s[1]),
      .trial     (sar_trial),
      .result    (sar_result),
      .done      (sar_done)
   );

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      logic sel;
      logic wr_rise;
      logic rd_fall;
      logic rd_rise;
      sel     = ~st_q.cs_s[1];
      wr_rise = rising(st_q.wr_s) & sel;
      rd_fall = falling(st_q.rd_s) & sel;
      rd_rise = rising(st_q.rd_s);
      st_d       = st_q;
      st_d.cs_s  = {st_q.cs_s[1:0], chip_sel_n};
      st_d.wr_s  = {st_q.wr_s[1:0], wr_n};
      st_d.rd_s  = {st_q.rd_s[1:0], rd_n};
      st_d.alt_s = {st_q.alt_s[1:0], alternate_timing_input};
      st_d.cmp_s = {st_q.cmp_s[0], cmp_above};
      st_d.ovr_s = {st_q.ovr_s[0], over_range};
      st_d.und_s = {st_q.und_s[0], under_range};
      st_d.alt_en_s = {st_q.alt_en_s[0], use_alt_timing};
      st_d.start = 1'b0;
      st_d.dac   = sar_trial;
      st_d.div   = (st_q.div == 8'(BIT_DIV - 1)) ? 8'h00 : st_q.div + 8'h01;
      // Read side: drive only while a selected read is open
      if (rd_fall) begin
         st_d.eoc_n = 1'b1;
         st_d.dout  = st_q.latch;
         st_d.oe    = 1'b1;
      end
      if (rd_rise || st_q.cs_s[1]) begin
         st_d.oe = 1'b0;
      end
      case (st_q.state)
         SAP_TRACK: begin
            st_d.hold = 1'b0;
            if (wr_rise) begin
               st_d.hold     = 1'b1;
               st_d.start    = 1'b1;
               st_d.conv_cnt = 16'h0000;
               st_d.eoc_n    = 1'b1;
               st_d.state    = SAP_CONVERT;
            end
         end
         SAP_CONVERT: begin
            st_d.conv_cnt = st_q.conv_cnt + 16'h0001;
            if (sar_done) begin
               st_d.state = SAP_LATCH;
               // Saturate against references; comparator ends agree anyway
               if (st_q.ovr_s[1]) begin
                  st_d.latch = SAP_CODE_ONES;
               end else if (st_q.und_s[1]) begin
                  st_d.latch = SAP_CODE_ZEROS;
               end else begin
                  st_d.latch = sar_result;
               end
            end
         end
         SAP_LATCH: begin
            // Latch settled one cycle before the flag falls
            st_d.eoc_n = 1'b0;
            st_d.hold  = 1'b0;
            st_d.state = SAP_TRACK;
         end
         default: begin
            st_d.state = SAP_TRACK;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         st_q       <= '0;
         st_q.cs_s  <= 3'h7;
         st_q.wr_s  <= 3'h7;
         st_q.rd_s  <= 3'h7;
         st_q.state <= SAP_TRACK;
         st_q.eoc_n <= 1'b1;
         st_q.latch <= SAP_RESULT_RST;
      end else begin
         st_q <= st_d;
      end
   end

   assign dac_code = st_q.dac;
   assign hold_en  = st_q.hold;
   assign eoc_n    = st_q.eoc_n;
   assign data_out = st_q.dout;
   assign data_oe  = st_q.oe;

   ////////////////////////////////////////////////////////////////////////
   // Internal timing: 10 steps of 24 cycles plus overhead, well under 600
   localparam int CONV_MAX = SAP_CONV_CYC;

   sequence wr_taken_s;
      st_q.state == SAP_TRACK && rising(st_q.wr_s) && !st_q.cs_s[1];
   endsequence

   sequence flag_low_s;
      !eoc_n && $past(st_q.state) == SAP_LATCH;
   endsequence

   unsel_wr_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      st_q.state == SAP_TRACK && st_q.cs_s[1] |=> st_q.state == SAP_TRACK)
      else $error("write accepted while deselected");

   track_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      $rose(eoc_n) && st_q.state == SAP_TRACK |-> !hold_en)
      else $error("hold while tracking");

   wr_start_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      wr_taken_s |=> hold_en && st_q.state == SAP_CONVERT)
      else $error("write edge did not start hold");

   conv_time_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      wr_taken_s ##1 !use_alt_timing |-> ##[1:CONV_MAX] flag_low_s)
      else $error("conversion exceeded time limit");

   latch_first_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      $fell(eoc_n) |-> $stable(st_q.latch) && $past(st_q.state) == SAP_LATCH)
      else $error("flag fell before result latched");

   rd_flag_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      falling(st_q.rd_s) && !st_q.cs_s[1] |=> eoc_n && data_oe
         && data_out == $past(st_q.latch))
      else $error("read did not raise flag or drive data");

   sat_hi_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      st_q.state == SAP_CONVERT && sar_done && st_q.ovr_s[1]
         |=> st_q.latch == SAP_CODE_ONES)
      else $error("over range not saturated");

   oe_rel_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      data_oe |-> !st_q.rd_s[2] && !st_q.cs_s[2])
      else $error("data driven outside selected read");
endmodule : sap_sequencer
`default_nettype wire

// >>> sap_pkg.sv
// Shared constants and types for the converter control sequencer
package sap_pkg;
   localparam int          SAP_DATA_W       = 10;
   localparam int          SAP_CLK_MHZ      = 100;
   localparam int          SAP_CONV_NS      = 6000;
   // Longest time rounds down to whole reference cycles
   localparam int          SAP_CONV_CYC     = (SAP_CONV_NS * SAP_CLK_MHZ) / 1000;
   // Internal bit clock near 4.2 MHz: 100 MHz / 24
   localparam int          SAP_BIT_DIV      = 24;
   // SAR and trial registers plus two comparator sync stages before a decision
   localparam int          SAP_SETTLE_CYC   = 4;
   localparam logic [9:0]  SAP_CODE_ONES    = 10'h3FF;
   localparam logic [9:0]  SAP_CODE_ZEROS   = 10'h000;
   localparam logic [9:0]  SAP_RESULT_RST   = 10'h000;

   typedef enum logic [3:0] {
      SAP_TRACK   = 4'h1,
      SAP_HOLD    = 4'h2,
      SAP_CONVERT = 4'h4,
      SAP_LATCH   = 4'h8
   } sap_state_t;
endpackage : sap_pkg

// >>> sap_sar_core.sv
// Successive-approximation register, one bit decided per step pulse
`timescale 1ns/1ns
`default_nettype none
module sap_sar_core
   import sap_pkg::*;
#(
   parameter int WIDTH = SAP_DATA_W
) (
   input  wire logic             ref_clk,
   input  wire logic             sys_rst,
   input  wire logic             start,
   input  wire logic             step,
   input  wire logic             cmp_above,
   output logic [WIDTH-1:0]      trial,
   output logic [WIDTH-1:0]      result,
   output logic                  done
);
   typedef struct packed {
      logic [WIDTH-1:0] code;
      logic [WIDTH-1:0] mask;
      logic             busy;
      logic             done;
   } sap_core_t;

   sap_core_t st_q;
   sap_core_t st_d;

   always_comb begin
      st_d      = st_q;
      st_d.done = 1'b0;
      if (start) begin
         st_d.code = '0;
         st_d.mask = {1'b1, {(WIDTH-1){1'b0}}};
         st_d.busy = 1'b1;
      end else if (st_q.busy && step) begin
         // Keep the trial bit only when the input lies above it
         if (cmp_above) begin
            st_d.code = st_q.code | st_q.mask;
         end
         st_d.mask = st_q.mask >> 1;
         if (st_q.mask[0]) begin
            st_d.busy = 1'b0;
            st_d.done = 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign trial  = st_q.code | st_q.mask;
   assign result = st_q.code;
   assign done   = st_q.done;
endmodule : sap_sar_core
`default_nettype wire

// >>> sap_host_model.sv
// Host bus and analog input model facing the converter sequencer
`timescale 1ns/1ns
`default_nettype none
module sap_host_model (
   input  wire logic       ref_clk,
   input  wire logic [9:0] dac_code,
   output logic            chip_sel_n,
   output logic            wr_n,
   output logic            rd_n,
   output logic            cmp_above,
   output logic            over_range,
   output logic            under_range
);
   logic [9:0] vin;
   // Input half a step above its code, so a tie keeps the bit
   assign cmp_above = (vin >= dac_code);
   initial begin
      chip_sel_n = 1'b1;
      wr_n = 1'b1;
      rd_n = 1'b1;
      over_range = 1'b0;
      under_range = 1'b0;
      vin = 10'h000;
   end
   ////////////////////////////////////////
   // Strobe low lasts 5 cycles, above the 3-cycle minimum
   task automatic start_acc(input logic sel, input logic is_rd);
      @(posedge ref_clk);
      chip_sel_n <= ~sel;
      @(posedge ref_clk);
      if (is_rd) begin
         rd_n <= 1'b0;
      end else begin
         wr_n <= 1'b0;
      end
      repeat (4) @(posedge ref_clk);
   endtask : start_acc
   task automatic end_acc();
      @(posedge ref_clk);
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      repeat (5) @(posedge ref_clk);
      chip_sel_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
   endtask : end_acc
endmodule : sap_host_model
`default_nettype wire

// >>> sap_sequencer_bench.sv
// Self-checking bench for the converter control sequencer
`timescale 1ns/1ns
`default_nettype none
module sap_sequencer_bench;
   import sap_pkg::*;
   logic       ref_clk = 1'b0;
   logic       sys_rst = 1'b1;
   logic       alt_clk = 1'b0;
   logic       use_alt = 1'b0;
   logic       chip_sel_n, wr_n, rd_n, cmp_above, over_range, under_range;
   logic [9:0] dac_code, data_out;
   logic       hold_en, eoc_n, data_oe;
   int         n_errors = 0;
   int         checks = 0;
   always #5 ref_clk = ~ref_clk;
   // Near 4.2 MHz, phase unrelated to the main clock
   always #121 alt_clk = ~alt_clk;
   sap_sequencer dut (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .chip_sel_n(chip_sel_n),
      .wr_n(wr_n), .rd_n(rd_n), .alternate_timing_input(alt_clk),
      .use_alt_timing(use_alt), .cmp_above(cmp_above),
      .over_range(over_range), .under_range(under_range),
      .dac_code(dac_code), .hold_en(hold_en), .eoc_n(eoc_n),
      .data_out(data_out), .data_oe(data_oe));
   sap_host_model host (
      .ref_clk(ref_clk), .dac_code(dac_code), .chip_sel_n(chip_sel_n),
      .wr_n(wr_n), .rd_n(rd_n), .cmp_above(cmp_above),
      .over_range(over_range), .under_range(under_range));
   ////////////////////////////////////////
   task automatic wrap_up();
      $display("errors %0d checks %0d", n_errors, checks);
      if (n_errors == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : wrap_up
   task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
      end
   endtask : chk
   // Write already at least 8 cycles old when the wait starts
   task automatic wait_eoc();
      for (int i = 0; i < SAP_CONV_CYC - 8; i++) begin
         if (eoc_n === 1'b0) break;
         @(posedge ref_clk);
         #1;
      end
      chk(eoc_n, 10'h000);
      if (eoc_n !== 1'b0) wrap_up();
      chk(hold_en, 10'h000);
      chk(data_oe, 10'h000);
   endtask : wait_eoc
   task automatic start_conv(input logic [9:0] v, input logic ov, un);
      @(posedge ref_clk);
      host.vin <= v;
      host.over_range <= ov;
      host.under_range <= un;
      host.start_acc(1'b1, 1'b0);
      host.end_acc();
      #1;
      chk(hold_en, 10'h001);
   endtask : start_conv
   task automatic read_chk(input logic [9:0] exp);
      host.start_acc(1'b1, 1'b1);
      #1;
      chk(eoc_n, 10'h001);
      chk(data_oe, 10'h001);
      chk(data_out, exp);
      host.end_acc();
      #1;
      chk(data_oe, 10'h000);
   endtask : read_chk
   task automatic convert(input logic [9:0] v, input logic ov, un,
                          input logic [9:0] exp);
      start_conv(v, ov, un);
      wait_eoc();
      read_chk(exp);
   endtask : convert
   ////////////////////////////////////////
   task automatic s_codes();
      logic [9:0] tbl [4] = '{10'h000, 10'h3FF, 10'h155, 10'h2AA};
      foreach (tbl[i]) convert(tbl[i], 1'b0, 1'b0, tbl[i]);
   endtask : s_codes
   task automatic s_range();
      convert(10'h155, 1'b1, 1'b0, SAP_CODE_ONES);
      convert(10'h2AA, 1'b0, 1'b1, SAP_CODE_ZEROS);
   endtask : s_range
   task automatic s_desel();
      host.start_acc(1'b0, 1'b0);
      host.end_acc();
      #1;
      chk(hold_en, 10'h000);
      start_conv(10'h0F0, 1'b0, 1'b0);
      wait_eoc();
      host.start_acc(1'b0, 1'b1);
      #1;
      chk(eoc_n, 10'h000);
      chk(data_oe, 10'h000);
      host.end_acc();
      read_chk(10'h0F0);
   endtask : s_desel
   // Second write lands mid-conversion and must start nothing
   task automatic s_busy();
      start_conv(10'h30F, 1'b0, 1'b0);
      host.start_acc(1'b1, 1'b0);
      host.end_acc();
      wait_eoc();
      read_chk(10'h30F);
      repeat (300) @(posedge ref_clk);
      #1;
      chk(eoc_n, 10'h001);
   endtask : s_busy
   task automatic s_alt();
      @(posedge ref_clk);
      use_alt <= 1'b1;
      convert(10'h2AA, 1'b0, 1'b0, 10'h2AA);
      @(posedge ref_clk);
      use_alt <= 1'b0;
   endtask : s_alt
   initial begin
      repeat (10) @(posedge ref_clk);
      sys_rst <= 1'b0;
      repeat (3) @(posedge ref_clk);
      #1;
      chk(eoc_n, 10'h001);
      s_codes();
      s_range();
      s_desel();
      s_busy();
      s_alt();
      wrap_up();
   end
endmodule : sap_sequencer_bench
`default_nettype wire
